// ### rtl/scan_drive_pkg.sv
package scan_drive_pkg;

    // Register offsets, byte addresses on the APB
    localparam int          ADDR_WIDTH     = 12;
    localparam int          DATA_WIDTH     = 32;
    localparam logic [11:0] PHASE_OFFSET   = 12'h000;
    localparam logic [11:0] CMD_OFFSET     = 12'h004;
    localparam logic [11:0] STATUS_OFFSET  = 12'h008;
    localparam logic [11:0] REFUSED_OFFSET = 12'h00c;

    // Winding register fields
    localparam int PHASE_WIDTH   = 4;
    localparam int PRI_PHASE_LSB = 0;
    localparam int SEC_PHASE_LSB = 4;

    // Pulse pairs; command bit is 2*pair for in/primary, 2*pair+1 for out/secondary
    localparam int PAIR_COUNT      = 6;
    localparam int CMD_WIDTH       = 2 * PAIR_COUNT;
    localparam int PAIR_SELECT     = 0;
    localparam int PAIR_NARROW_PRI = 1;
    localparam int PAIR_MEDIUM_PRI = 2;
    localparam int PAIR_NARROW_SEC = 3;
    localparam int PAIR_MEDIUM_SEC = 4;
    localparam int PAIR_POPUP      = 5;

    // Status register fields
    localparam int TELLTALE_COUNT     = 6;
    localparam int ST_COVER_CLOSED    = 0;
    localparam int ST_COVER_OPEN      = 1;
    localparam int ST_NARROW_IN       = 2;
    localparam int ST_NARROW_OUT      = 3;
    localparam int ST_MEDIUM_IN       = 4;
    localparam int ST_MEDIUM_OUT      = 5;
    localparam int ST_COVER_CONFLICT  = 6;
    localparam int ST_NARROW_CONFLICT = 7;
    localparam int ST_MEDIUM_CONFLICT = 8;

    // Reset values
    localparam logic [7:0]  PHASE_RESET    = 8'h00;
    localparam logic [5:0]  TELLTALE_RESET = 6'h3f;
    localparam logic [11:0] CMD_RESET      = 12'h000;

    // Pulse timing
    localparam int PULSE_TIME_MS = 500;
    localparam int CLK_FREQ_HZ   = 100_000_000;
    localparam int PULSE_CYCLES  = PULSE_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int COUNT_WIDTH   = 26;

    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b01,
        PULSE_RUN  = 2'b10
    } pulse_state_type;

endpackage

// ### rtl/pulse_pair_if.sv
`timescale 1ns/1ns
interface pulse_pair_if;
    logic [1:0] request;
    logic [1:0] drive;
    logic [1:0] refused;

    modport controller (output request, input drive, input refused);
    modport generator (input request, output drive, output refused);
endinterface

// ### rtl/pulse_pair.sv
`timescale 1ns/1ns
module pulse_pair #(
    parameter int PULSE_CYCLES = scan_drive_pkg::PULSE_CYCLES,
    parameter int COUNT_WIDTH  = scan_drive_pkg::COUNT_WIDTH
) (
    // Clock and reset
    input wire logic            clk,
    input wire logic            reset,
    // Request and drive
    pulse_pair_if.generator     link
);

    if (PULSE_CYCLES < 2 || PULSE_CYCLES > (2 ** COUNT_WIDTH)) begin
        $error("pulse_pair: PULSE_CYCLES does not fit the counter");
    end

    localparam logic [COUNT_WIDTH-1:0] LAST =
        COUNT_WIDTH'(PULSE_CYCLES - 1);

    scan_drive_pkg::pulse_state_type state_reg;
    scan_drive_pkg::pulse_state_type state_next;
    logic [COUNT_WIDTH-1:0]          cnt_reg;
    logic [COUNT_WIDTH-1:0]          cnt_next;
    logic [1:0]                      drive_reg;
    logic [1:0]                      drive_next;
    logic [1:0]                      refused_reg;
    logic [1:0]                      refused_next;

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        drive_next   = drive_reg;
        refused_next = 2'h0;
        case (state_reg)
            scan_drive_pkg::PULSE_IDLE: begin
                // Both sides at once would fight the mechanism
                if (link.request == 2'h3) begin
                    refused_next = 2'h3;
                end else if (link.request != 2'h0) begin
                    drive_next = link.request;
                    cnt_next   = '0;
                    state_next = scan_drive_pkg::PULSE_RUN;
                end
            end
            scan_drive_pkg::PULSE_RUN: begin
                // Either side is refused until the pulse is over
                refused_next = link.request;
                if (cnt_reg == LAST) begin
                    drive_next = 2'h0;
                    state_next = scan_drive_pkg::PULSE_IDLE;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                drive_next = 2'h0;
                state_next = scan_drive_pkg::PULSE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg   <= scan_drive_pkg::PULSE_IDLE;
            cnt_reg     <= '0;
            drive_reg   <= 2'h0;
            refused_reg <= 2'h0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            drive_reg   <= drive_next;
            refused_reg <= refused_next;
        end
    end

    assign link.drive   = drive_reg;
    assign link.refused = refused_reg;

endmodule

// ### rtl/scan_drive_ctrl.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
module scan_drive_ctrl #(
    parameter int PULSE_CYCLES = scan_drive_pkg::PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Scan motor windings
    output logic      [3:0]  PRI_WINDING,
    output logic      [3:0]  SEC_WINDING,
    // Pulse commands
    output logic             PRI_SELECT,
    output logic             SEC_SELECT,
    output logic             NARROW_PRI_IN,
    output logic             NARROW_PRI_OUT,
    output logic             MEDIUM_PRI_IN,
    output logic             MEDIUM_PRI_OUT,
    output logic             NARROW_SEC_IN,
    output logic             NARROW_SEC_OUT,
    output logic             MEDIUM_SEC_IN,
    output logic             MEDIUM_SEC_OUT,
    output logic             POPUP_IN,
    output logic             POPUP_OUT,
    // Position telltales, active low
    input  wire logic        COVER_CLOSED_N,
    input  wire logic        COVER_OPEN_N,
    input  wire logic        NARROW_IN_N,
    input  wire logic        NARROW_OUT_N,
    input  wire logic        MEDIUM_IN_N,
    input  wire logic        MEDIUM_OUT_N
);

    localparam int PW = scan_drive_pkg::PHASE_WIDTH;
    localparam int CW = scan_drive_pkg::CMD_WIDTH;
    localparam int TW = scan_drive_pkg::TELLTALE_COUNT;

    function automatic logic addr_known(input logic [11:0] addr);
        addr_known = (addr == scan_drive_pkg::PHASE_OFFSET)
                  || (addr == scan_drive_pkg::CMD_OFFSET)
                  || (addr == scan_drive_pkg::STATUS_OFFSET)
                  || (addr == scan_drive_pkg::REFUSED_OFFSET);
    endfunction

    function automatic logic [31:0] widen(input logic [15:0] value);
        widen = {16'h0000, value};
    endfunction

    pulse_pair_if pair_link [scan_drive_pkg::PAIR_COUNT] ();

    // APB state
    logic          pready_reg;
    logic          pready_next;
    logic          pslverr_reg;
    logic          pslverr_next;
    logic [31:0]   prdata_reg;
    logic [31:0]   prdata_next;
    logic          setup;
    logic          write_done;

    // Software state
    logic [2*PW-1:0] phase_reg;
    logic [2*PW-1:0] phase_next;
    logic [CW-1:0]   request_reg;
    logic [CW-1:0]   request_next;
    logic [CW-1:0]   refused_reg;
    logic [CW-1:0]   refused_next;

    // Telltale synchroniser
    logic [TW-1:0] tell_meta_reg;
    logic [TW-1:0] tell_meta_next;
    logic [TW-1:0] tell_sync_reg;
    logic [TW-1:0] tell_sync_next;
    logic [TW-1:0] position;
    logic [2:0]    conflict;

    // Gathered from the pulse generators
    logic [CW-1:0] drive_all;
    logic [CW-1:0] refused_all;

    for (genvar p = 0; p < scan_drive_pkg::PAIR_COUNT; p++) begin : g_pair
        pulse_pair #(
            .PULSE_CYCLES (PULSE_CYCLES),
            .COUNT_WIDTH  (scan_drive_pkg::COUNT_WIDTH)
        ) u_pair (
            .clk   (CLK),
            .reset (RESET),
            .link  (pair_link[p])
        );
        assign pair_link[p].request = request_reg[2*p +: 2];
        assign drive_all[2*p +: 2]  = pair_link[p].drive;
        assign refused_all[2*p +: 2] = pair_link[p].refused;
    end

    // Telltales decoded to active-high positions
    always_comb begin
        position[scan_drive_pkg::ST_COVER_CLOSED] =
            ~tell_sync_reg[scan_drive_pkg::ST_COVER_CLOSED];
        position[scan_drive_pkg::ST_COVER_OPEN] =
            ~tell_sync_reg[scan_drive_pkg::ST_COVER_OPEN];
        position[scan_drive_pkg::ST_NARROW_IN] =
            ~tell_sync_reg[scan_drive_pkg::ST_NARROW_IN];
        position[scan_drive_pkg::ST_NARROW_OUT] =
            ~tell_sync_reg[scan_drive_pkg::ST_NARROW_OUT];
        position[scan_drive_pkg::ST_MEDIUM_IN] =
            ~tell_sync_reg[scan_drive_pkg::ST_MEDIUM_IN];
        position[scan_drive_pkg::ST_MEDIUM_OUT] =
            ~tell_sync_reg[scan_drive_pkg::ST_MEDIUM_OUT];
        // Both ends reported at once points at a broken switch
        conflict[0] = position[scan_drive_pkg::ST_COVER_CLOSED]
                    & position[scan_drive_pkg::ST_COVER_OPEN];
        conflict[1] = position[scan_drive_pkg::ST_NARROW_IN]
                    & position[scan_drive_pkg::ST_NARROW_OUT];
        conflict[2] = position[scan_drive_pkg::ST_MEDIUM_IN]
                    & position[scan_drive_pkg::ST_MEDIUM_OUT];
    end

    always_comb begin
        tell_meta_next = {MEDIUM_OUT_N, MEDIUM_IN_N, NARROW_OUT_N,
                          NARROW_IN_N, COVER_OPEN_N, COVER_CLOSED_N};
        tell_sync_next = tell_meta_reg;
    end

    // APB: zero wait, answer in the first access cycle
    always_comb begin
        setup      = PSEL & ~PENABLE;
        write_done = PSEL & PENABLE & pready_reg & PWRITE;
        pready_next  = setup;
        pslverr_next = setup & ~addr_known(PADDR);
        prdata_next  = prdata_reg;
        if (setup) begin
            case (PADDR)
                scan_drive_pkg::PHASE_OFFSET:
                    prdata_next = widen({8'h00, phase_reg});
                scan_drive_pkg::CMD_OFFSET:
                    prdata_next = widen({4'h0, drive_all});
                scan_drive_pkg::STATUS_OFFSET:
                    prdata_next = widen({7'h00, conflict, position});
                scan_drive_pkg::REFUSED_OFFSET:
                    prdata_next = widen({4'h0, refused_reg});
                default:
                    prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Software registers
    always_comb begin
        phase_next   = phase_reg;
        request_next = scan_drive_pkg::CMD_RESET;
        refused_next = refused_reg;
        if (write_done && PADDR == scan_drive_pkg::PHASE_OFFSET) begin
            phase_next = PWDATA[2*PW-1:0];
        end
        // A command write is a one-cycle request per set bit
        if (write_done && PADDR == scan_drive_pkg::CMD_OFFSET) begin
            request_next = PWDATA[CW-1:0];
        end
        if (write_done && PADDR == scan_drive_pkg::REFUSED_OFFSET) begin
            refused_next = refused_reg & ~PWDATA[CW-1:0];
        end
        // Set after clear, so a refusal in the clearing cycle stays
        refused_next = refused_next | refused_all;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            prdata_reg    <= 32'h0000_0000;
            phase_reg     <= scan_drive_pkg::PHASE_RESET;
            request_reg   <= scan_drive_pkg::CMD_RESET;
            refused_reg   <= scan_drive_pkg::CMD_RESET;
            tell_meta_reg <= scan_drive_pkg::TELLTALE_RESET;
            tell_sync_reg <= scan_drive_pkg::TELLTALE_RESET;
        end else begin
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            prdata_reg    <= prdata_next;
            phase_reg     <= phase_next;
            request_reg   <= request_next;
            refused_reg   <= refused_next;
            tell_meta_reg <= tell_meta_next;
            tell_sync_reg <= tell_sync_next;
        end
    end

    // Outputs, all from flip-flops
    assign PREADY  = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign PRDATA  = prdata_reg;

    // Windings are not interlocked with the select relay; software owns it
    assign PRI_WINDING =
        phase_reg[scan_drive_pkg::PRI_PHASE_LSB +: PW];
    assign SEC_WINDING =
        phase_reg[scan_drive_pkg::SEC_PHASE_LSB +: PW];

    assign PRI_SELECT =
        drive_all[2*scan_drive_pkg::PAIR_SELECT];
    assign SEC_SELECT =
        drive_all[2*scan_drive_pkg::PAIR_SELECT+1];
    assign NARROW_PRI_IN =
        drive_all[2*scan_drive_pkg::PAIR_NARROW_PRI];
    assign NARROW_PRI_OUT =
        drive_all[2*scan_drive_pkg::PAIR_NARROW_PRI+1];
    assign MEDIUM_PRI_IN =
        drive_all[2*scan_drive_pkg::PAIR_MEDIUM_PRI];
    assign MEDIUM_PRI_OUT =
        drive_all[2*scan_drive_pkg::PAIR_MEDIUM_PRI+1];
    assign NARROW_SEC_IN =
        drive_all[2*scan_drive_pkg::PAIR_NARROW_SEC];
    assign NARROW_SEC_OUT =
        drive_all[2*scan_drive_pkg::PAIR_NARROW_SEC+1];
    assign MEDIUM_SEC_IN =
        drive_all[2*scan_drive_pkg::PAIR_MEDIUM_SEC];
    assign MEDIUM_SEC_OUT =
        drive_all[2*scan_drive_pkg::PAIR_MEDIUM_SEC+1];
    assign POPUP_IN =
        drive_all[2*scan_drive_pkg::PAIR_POPUP];
    assign POPUP_OUT =
        drive_all[2*scan_drive_pkg::PAIR_POPUP+1];

endmodule

// ### testbench/scan_drive_chk.sv
`timescale 1ns/1ns
module scan_drive_chk #(
    parameter int PULSE_CYCLES = 20
) (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Windings
    input wire logic [3:0]  PRI_WINDING,
    input wire logic [3:0]  SEC_WINDING,
    // Pulses
    input wire logic        PRI_SELECT,
    input wire logic        SEC_SELECT,
    input wire logic        NARROW_PRI_IN,
    input wire logic        NARROW_PRI_OUT,
    input wire logic        MEDIUM_PRI_IN,
    input wire logic        MEDIUM_PRI_OUT,
    input wire logic        NARROW_SEC_IN,
    input wire logic        NARROW_SEC_OUT,
    input wire logic        MEDIUM_SEC_IN,
    input wire logic        MEDIUM_SEC_OUT,
    input wire logic        POPUP_IN,
    input wire logic        POPUP_OUT
);
    logic [11:0] p;
    logic        wph;
    int          cnt_reg [12];
    int          cnt_next [12];
    assign p = {POPUP_OUT, POPUP_IN, MEDIUM_SEC_OUT, MEDIUM_SEC_IN,
        NARROW_SEC_OUT, NARROW_SEC_IN, MEDIUM_PRI_OUT, MEDIUM_PRI_IN,
        NARROW_PRI_OUT, NARROW_PRI_IN, SEC_SELECT, PRI_SELECT};
    assign wph = PSEL && PENABLE && PREADY && PWRITE
        && PADDR == scan_drive_pkg::PHASE_OFFSET;
    // High-cycle counter per output, cleared while low
    always_comb begin
        for (int i = 0; i < 12; i++) cnt_next[i] = p[i] ? cnt_reg[i] + 1 : 0;
    end
    always_ff @(posedge CLK) begin
        for (int i = 0; i < 12; i++) cnt_reg[i] <= RESET ? 0 : cnt_next[i];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    for (genvar i = 0; i < 12; i++) begin : g_pulse
        chk_pulse_width: assert property
            ($fell(p[i]) |-> cnt_reg[i] == PULSE_CYCLES)
            else $error("pulse width wrong");
        chk_pulse_max: assert property (cnt_reg[i] <= PULSE_CYCLES)
            else $error("pulse too long");
        chk_pulse_cause: assert property ($rose(p[i]) |->
            $past(PSEL && PENABLE && PREADY && PWRITE
            && PADDR == scan_drive_pkg::CMD_OFFSET, 2))
            else $error("pulse without command");
    end
    chk_no_opposed: assert property
        ((p & (p >> 1) & 12'h555) == 12'h000)
        else $error("opposing commands together");
    chk_zero_wait: assert property ((PSEL && !PENABLE) |=> PREADY)
        else $error("ready late");
    chk_ready_cause: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    chk_unmapped_err: assert property (PREADY |-> PSLVERR
        == !(PADDR inside {12'h000, 12'h004, 12'h008, 12'h00c}))
        else $error("slave error wrong");
    chk_winding_load: assert property
        (wph |=> {SEC_WINDING, PRI_WINDING} == $past(PWDATA[7:0]))
        else $error("winding not loaded");
    chk_winding_hold: assert property
        (!wph |=> $stable({SEC_WINDING, PRI_WINDING}))
        else $error("winding changed");
endmodule

bind scan_drive_ctrl scan_drive_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PRI_WINDING(PRI_WINDING),
    .SEC_WINDING(SEC_WINDING), .PRI_SELECT(PRI_SELECT),
    .SEC_SELECT(SEC_SELECT), .NARROW_PRI_IN(NARROW_PRI_IN),
    .NARROW_PRI_OUT(NARROW_PRI_OUT), .MEDIUM_PRI_IN(MEDIUM_PRI_IN),
    .MEDIUM_PRI_OUT(MEDIUM_PRI_OUT), .NARROW_SEC_IN(NARROW_SEC_IN),
    .NARROW_SEC_OUT(NARROW_SEC_OUT), .MEDIUM_SEC_IN(MEDIUM_SEC_IN),
    .MEDIUM_SEC_OUT(MEDIUM_SEC_OUT), .POPUP_IN(POPUP_IN),
    .POPUP_OUT(POPUP_OUT));

// ### testbench/scan_mech_model.sv
`timescale 1ns/1ns
module scan_mech_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Slit drive, either chain
    input wire logic narrow_in,
    input wire logic narrow_out,
    input wire logic medium_in,
    input wire logic medium_out,
    // Position switches, low when made
    output logic     narrow_in_n,
    output logic     narrow_out_n,
    output logic     medium_in_n,
    output logic     medium_out_n
);
    logic [3:0] drv_q;
    // Slit travels while driven, so neither switch is made meanwhile
    always_ff @(posedge clk) begin
        drv_q <= {medium_out, medium_in, narrow_out, narrow_in};
        if (reset) begin
            {narrow_in_n, narrow_out_n, medium_in_n, medium_out_n} <= 4'hf;
        end else begin
            if (narrow_in || narrow_out) {narrow_in_n, narrow_out_n} <= 2'h3;
            else if (drv_q[0]) {narrow_in_n, narrow_out_n} <= 2'h1;
            else if (drv_q[1]) {narrow_in_n, narrow_out_n} <= 2'h2;
            if (medium_in || medium_out) {medium_in_n, medium_out_n} <= 2'h3;
            else if (drv_q[2]) {medium_in_n, medium_out_n} <= 2'h1;
            else if (drv_q[3]) {medium_in_n, medium_out_n} <= 2'h2;
        end
    end
endmodule

// ### testbench/scan_drive_ctrl_tb.sv
`timescale 1ns/1ns
module scan_drive_ctrl_tb;
    localparam int PC = 20;
    logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, er, cc_n = 1, co_n = 1;
    logic [3:0]  pri_w, sec_w;
    wire  [11:0] pv;
    logic [11:0] seen = 0;
    logic [1:0]  nar = 0, med = 0;
    logic        ni_n, no_n, mi_n, mo_n;
    int          miscompares = 0, cmp_count = 0;
    scan_drive_ctrl #(.PULSE_CYCLES(PC)) i_scan_drive_ctrl (
        .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PRI_WINDING(pri_w),
        .SEC_WINDING(sec_w), .PRI_SELECT(pv[0]), .SEC_SELECT(pv[1]),
        .NARROW_PRI_IN(pv[2]), .NARROW_PRI_OUT(pv[3]),
        .MEDIUM_PRI_IN(pv[4]), .MEDIUM_PRI_OUT(pv[5]),
        .NARROW_SEC_IN(pv[6]), .NARROW_SEC_OUT(pv[7]),
        .MEDIUM_SEC_IN(pv[8]), .MEDIUM_SEC_OUT(pv[9]), .POPUP_IN(pv[10]),
        .POPUP_OUT(pv[11]), .COVER_CLOSED_N(cc_n), .COVER_OPEN_N(co_n),
        .NARROW_IN_N(ni_n), .NARROW_OUT_N(no_n), .MEDIUM_IN_N(mi_n),
        .MEDIUM_OUT_N(mo_n));
    scan_mech_model i_scan_mech_model (
        .clk(clk), .reset(reset), .narrow_in(pv[2] | pv[6]),
        .narrow_out(pv[3] | pv[7]), .medium_in(pv[4] | pv[8]),
        .medium_out(pv[5] | pv[9]), .narrow_in_n(ni_n),
        .narrow_out_n(no_n), .medium_in_n(mi_n), .medium_out_n(mo_n));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(negedge clk) seen <= seen | pv;
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task timeout(input string m);
        miscompares++;
        $display("CHECK FAILED at %0t: %s timed out", $time, m);
        end_of_test;
    endtask
    // Zero-wait slave, but the wait stays open to a bound anyway
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1;
        n = 0;
        // Ready, data and error are all taken at one rising edge
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout("apb");
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
        repeat (3) @(posedge clk);
        apb(0, a, 0);
        chk(rd, e, m);
    endtask
    function logic [31:0] est();
        est = {23'h0, &med, &nar, !cc_n && !co_n, med, nar, !co_n, !cc_n};
    endfunction
    task measure(input int b);
        int n, w;
        n = 0;
        w = 0;
        while (pv[b] !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (pv[b] !== 1'b1) timeout("pulse start");
        while (pv[b] === 1'b1 && w < PC + 5) begin
            @(negedge clk);
            w++;
        end
        chk(w, PC, "pulse width");
    endtask
    task t_reset;
        rdchk(12'h000, 0, "phase reset");
        chk({sec_w, pri_w}, 0, "windings reset");
        rdchk(12'h004, 0, "cmd reset");
        rdchk(12'h008, 0, "status reset");
        rdchk(12'h00c, 0, "refused reset");
        rdchk(12'h010, 0, "unmapped data");
        chk(er, 1, "unmapped error");
        $display("test reset done");
    endtask
    task t_windings;
        logic [7:0] v [4];
        v = '{8'h5a, 8'ha5, 8'hff, 8'h00};
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h000, {24'h0, v[i]});
            @(negedge clk);
            chk({sec_w, pri_w}, v[i], "windings");
            rdchk(12'h000, v[i], "phase readback");
        end
        $display("test windings done");
    endtask
    // Every command bit in turn; slits move and the switches follow
    task t_pulses;
        for (int b = 0; b < 12; b++) begin
            seen = 0;
            apb(1, 12'h004, 32'h1 << b);
            measure(b);
            chk(seen, 12'h1 << b, "only one output");
            if (b / 2 == 1 || b / 2 == 3) nar = b[0] ? 2'b10 : 2'b01;
            if (b / 2 == 2 || b / 2 == 4) med = b[0] ? 2'b10 : 2'b01;
            rdchk(12'h008, est(), "slit status");
        end
        $display("test pulses done");
    endtask
    task t_refuse;
        seen = 0;
        apb(1, 12'h004, 32'h1);
        apb(1, 12'h004, 32'h2);
        rdchk(12'h00c, 32'h2, "busy refused");
        apb(1, 12'h004, 32'hc);
        rdchk(12'h00c, 32'he, "both sides refused");
        // Select pulse is part way through here; let it run out
        for (int k = 0; k < PC && pv[0] === 1'b1; k++) @(negedge clk);
        chk(pv, 0, "select pulse over");
        chk(seen, 12'h001, "refused outputs low");
        apb(1, 12'h00c, 32'he);
        rdchk(12'h00c, 0, "refused cleared");
        apb(1, 12'h004, 32'h2);
        measure(1);
        $display("test refuse done");
    endtask
    task t_cover;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {co_n, cc_n} <= 2'(k);
            // Expectation must see the new pin levels
            @(negedge clk);
            rdchk(12'h008, est(), "cover status");
        end
        $display("test cover done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        t_reset;
        t_windings;
        t_pulses;
        t_refuse;
        t_cover;
        end_of_test;
    end
    initial begin
        #500000;
        timeout("run");
    end
endmodule
